// file: gcap_defs.svh
// Constants for the gauge control register, status flags and charge count.
// Assumes nothing beyond inclusion by the package and the design modules.
`ifndef GCAP_DEFS_SVH
`define GCAP_DEFS_SVH

// Control register layout and power-up value: sleep, code 111, alert mode, running.
`define GCAP_CTRL_RST 8'h3c
`define GCAP_MODE_HI 7
`define GCAP_MODE_LO 6
`define GCAP_PRE_HI 5
`define GCAP_PRE_LO 3
`define GCAP_PIN_HI 2
`define GCAP_PIN_LO 1
`define GCAP_SHDN_BIT 0

// Prescaler codes at or above this one all select the largest factor.
`define GCAP_PRE_MAX_CODE 3'h6
`define GCAP_PRE_MAX_FACTOR 13'h1000

// Status register: bit 7 reserved, bit 0 comes up set.
`define GCAP_STAT_RST 8'h01
`define GCAP_STAT_CUR 6
`define GCAP_STAT_OVF 5
`define GCAP_STAT_TEMP 4
`define GCAP_STAT_CHI 3
`define GCAP_STAT_CLO 2
`define GCAP_STAT_VOLT 1
`define GCAP_STAT_UVLO 0

// Charge count values.
`define GCAP_COUNT_RST 16'h7fff
`define GCAP_COUNT_FULL 16'hffff
`define GCAP_COUNT_ZERO 16'h0000

`endif

// file: gcap_pkg.sv
// Types shared by the gauge control block and its charge prescaler.
// Assumes the constants header is on the include path.
`include "gcap_defs.svh"

package gcap_pkg;

    // Converter mode field, Gray ordered along sleep, single, auto, scan.
    typedef enum logic [1:0] {
        GCAP_MODE_SLEEP = 2'h0,
        GCAP_MODE_SINGLE = 2'h1,
        GCAP_MODE_AUTO = 2'h3,
        GCAP_MODE_SCAN = 2'h2
    } gcap_mode_t;

    // Alert pin configuration field.
    typedef enum logic [1:0] {
        GCAP_PIN_OFF = 2'h0,
        GCAP_PIN_CHG_FULL = 2'h1,
        GCAP_PIN_ALERT = 2'h2,
        GCAP_PIN_BOTH = 2'h3
    } gcap_pin_t;

    // Threshold and supply events reported by the measurement side, one-cycle pulses.
    typedef struct packed {
        logic cur;
        logic temp;
        logic chg_hi;
        logic chg_lo;
        logic volt;
        logic uvlo;
    } gcap_evt_t;

    // Whole state of the control block.
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [15:0] accumulated_charge_count;
        logic alert;
    } gcap_state_t;

    // Whole state of the prescaler.
    typedef struct packed {
        logic signed [13:0] resid;
        logic inc;
        logic dec;
    } gcap_pre_state_t;

endpackage

// file: gcap_presc.sv
// Charge prescaler: folds analog integrator steps into charge count steps.
// Assumes step pulses are synchronous to clk and never both high by intent.
`timescale 1ns/100ps
`include "gcap_defs.svh"

module gcap_presc
(
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [2:0] code, // Prescaler field.
    input wire logic hold, // Analog section shut down.
    input wire logic step_up, // Integrator step, charging.
    input wire logic step_dn, // Integrator step, discharging.
    output logic inc, // Count up one, one-cycle pulse.
    output logic dec // Count down one, one-cycle pulse.
);

    // Factor is 2 to the power twice the code, clamped so it never passes 4096.
    function automatic logic [12:0] factor(input logic [2:0] c);
        if (c >= `GCAP_PRE_MAX_CODE) // RULE_03
        begin
            return `GCAP_PRE_MAX_FACTOR;
        end
        return 13'(13'h1 << {c, 1'b0}); // RULE_14
    endfunction

    gcap_pkg::gcap_pre_state_t s_q, s_d;
    logic signed [13:0] lim;

    assign lim = 14'(factor(code));

    // Residue counts integrator steps until a full factor is reached either way.
    always_comb
    begin
        s_d = s_q;
        s_d.inc = 1'b0;
        s_d.dec = 1'b0;
        if (hold)
        begin
            s_d.resid = 14'sh0; // RULE_12
        end
        else if (step_up && !step_dn)
        begin
            if (s_q.resid + 14'sh1 >= lim) // RULE_02
            begin
                s_d.resid = 14'sh0;
                s_d.inc = 1'b1;
            end
            else
            begin
                s_d.resid = s_q.resid + 14'sh1;
            end
        end
        else if (step_dn && !step_up)
        begin
            if (s_q.resid - 14'sh1 <= -lim) // RULE_02
            begin
                s_d.resid = 14'sh0;
                s_d.dec = 1'b1;
            end
            else
            begin
                s_d.resid = s_q.resid - 14'sh1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign inc = s_q.inc;
    assign dec = s_q.dec;

    property p_presc_max;
        @(posedge clk) disable iff (rst)
        (code >= 3'h6) |-> (lim == 14'sh1000);
    endproperty
    a_presc_max: assert property (p_presc_max) else $error("Prescaler factor not 4096."); // RULE_03

    property p_presc_hold;
        @(posedge clk) disable iff (rst)
        hold |=> (s_q.resid == 14'sh0) && !inc && !dec;
    endproperty
    a_presc_hold: assert property (p_presc_hold) else $error("Residue kept in shutdown."); // RULE_12

endmodule

// file: gcap_ctrl.sv
// Control register, status flags, charge count and dual-use alert pin of the gauge.
// Assumes the serial interface decodes host accesses into the strobes below.
`timescale 1ns/100ps
`include "gcap_defs.svh"

// Notes on behaviour
// [RULE_01] One 8-bit control: mode, prescale, pin, shutdown.
// [RULE_02] Count LSB is step times factor over 4096.
// [RULE_03] Codes 110 and 111 both give 4096.
// [RULE_04] Pin field resets to alert mode.
// [RULE_05] Alert mode: threshold or wrap pulls pin low.
// [RULE_06] Alert response from host releases the pin.
// [RULE_07] Pin stays low across configuration change.
// [RULE_08] Charge-full mode: low pin loads count FFFFh.
// [RULE_09] Disabled mode: pin neither drives nor listens; an alert latched before the change still drives it low.
// [RULE_10] Host never writes pin code 11.
// [RULE_11] Shutdown stops analog, keeps registers and interface.
// [RULE_12] Shutdown stops counting and drops residue.
// [RULE_13] Mode 00 sleeps; 01 converts once, returns 00.
// [RULE_14] Factor is two to twice the code.
// [RULE_15] Count wraps and sets the overflow flag.
// [RULE_16] Status flags clear on read, set wins.
module gcap_ctrl
(
    input wire logic clk, // System clock, 20 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic ctrl_wr, // Control register write strobe.
    input wire logic [7:0] ctrl_wdata, // Control register write data.
    output logic [7:0] ctrl_rdata, // Control register contents.
    input wire logic stat_rd, // Status register read strobe.
    output logic [7:0] stat_rdata, // Status register contents.
    input wire logic accumulated_charge_count_wr, // Charge count write strobe.
    input wire logic [15:0] accumulated_charge_count_wdata, // Charge count write data.
    output logic [15:0] accumulated_charge_count_rdata, // Charge count contents.
    input wire logic step_up, // Integrator step, charging.
    input wire logic step_dn, // Integrator step, discharging.
    input wire gcap_pkg::gcap_evt_t meas_evt, // Threshold and supply events.
    input wire logic seq_done, // Conversion sequence finished, pulse.
    input wire logic ara_done, // Successful alert response, pulse.
    input wire logic pin_i, // Alert pin level as seen.
    output logic pin_o, // Alert pin driven level.
    output logic pin_oe_n, // Alert pin enable, low while driving.
    output logic analog_on, // Analog section powered.
    output gcap_pkg::gcap_mode_t adc_mode // Converter mode to the converter.
);

    gcap_pkg::gcap_state_t s_q, s_d;
    gcap_pkg::gcap_pin_t pin_cfg;
    logic shdn;
    logic cnt_inc, cnt_dec;
    logic chg_full;
    logic wrap;
    logic [7:0] stat_set;

    // Field views of the control register.
    assign pin_cfg = gcap_pkg::gcap_pin_t'(s_q.ctrl[`GCAP_PIN_HI:`GCAP_PIN_LO]); // RULE_01
    assign shdn = s_q.ctrl[`GCAP_SHDN_BIT];
    assign adc_mode = gcap_pkg::gcap_mode_t'(s_q.ctrl[`GCAP_MODE_HI:`GCAP_MODE_LO]);

    // The prescaler keeps running off the registered field, so a new code applies at once.
    gcap_presc gcap_presc_inst
    (
        .clk(clk),
        .rst(rst),
        .code(s_q.ctrl[`GCAP_PRE_HI:`GCAP_PRE_LO]),
        .hold(shdn),
        .step_up(step_up),
        .step_dn(step_dn),
        .inc(cnt_inc),
        .dec(cnt_dec)
    );

    // Charge-full input only listens when its mode bit is set; code 11 listens too.
    assign chg_full = pin_cfg[0] && !pin_i; // RULE_08 RULE_09
    assign wrap = (cnt_inc && s_q.accumulated_charge_count == `GCAP_COUNT_FULL) ||
        (cnt_dec && s_q.accumulated_charge_count == `GCAP_COUNT_ZERO);

    // New flag sets this cycle; bit 7 is reserved and never sets.
    always_comb
    begin
        stat_set = 8'h00;
        stat_set[`GCAP_STAT_CUR] = meas_evt.cur;
        stat_set[`GCAP_STAT_OVF] = wrap && !chg_full && !accumulated_charge_count_wr;
        stat_set[`GCAP_STAT_TEMP] = meas_evt.temp;
        stat_set[`GCAP_STAT_CHI] = meas_evt.chg_hi;
        stat_set[`GCAP_STAT_CLO] = meas_evt.chg_lo;
        stat_set[`GCAP_STAT_VOLT] = meas_evt.volt;
        stat_set[`GCAP_STAT_UVLO] = meas_evt.uvlo;
    end

    // Next state of control, status, charge count and alert latch.
    always_comb
    begin
        s_d = s_q;
        if (ctrl_wr)
        begin
            s_d.ctrl = ctrl_wdata; // RULE_01 RULE_10
        end
        else if (adc_mode == gcap_pkg::GCAP_MODE_SINGLE && seq_done)
        begin
            s_d.ctrl[`GCAP_MODE_HI:`GCAP_MODE_LO] = gcap_pkg::GCAP_MODE_SLEEP; // RULE_13
        end
        // Read clears, but a flag raised in the same cycle survives.
        s_d.stat = (stat_rd ? 8'h00 : s_q.stat) | stat_set; // RULE_16
        // Charge-full beats a host write, which beats counting.
        if (chg_full)
        begin
            s_d.accumulated_charge_count = `GCAP_COUNT_FULL; // RULE_08
        end
        else if (accumulated_charge_count_wr)
        begin
            s_d.accumulated_charge_count = accumulated_charge_count_wdata;
        end
        else if (cnt_inc)
        begin
            s_d.accumulated_charge_count = s_q.accumulated_charge_count + 16'h0001; // RULE_15
        end
        else if (cnt_dec)
        begin
            s_d.accumulated_charge_count = s_q.accumulated_charge_count - 16'h0001; // RULE_15
        end
        // The latch ignores later configuration changes until the response arrives.
        if (ara_done)
        begin
            s_d.alert = 1'b0; // RULE_06 RULE_07
        end
        if (pin_cfg[1] && (stat_set[7:1] != 7'h00))
        begin
            s_d.alert = 1'b1; // RULE_05
        end
    end

    // State register; the reset values are the power-up defaults.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q.ctrl <= `GCAP_CTRL_RST; // RULE_04
            s_q.stat <= `GCAP_STAT_RST;
            s_q.accumulated_charge_count <= `GCAP_COUNT_RST;
            s_q.alert <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Open-drain pin: only ever pulls low. Shutdown touches none of the registers.
    assign pin_o = 1'b0;
    assign pin_oe_n = !s_q.alert;
    assign analog_on = !shdn; // RULE_11
    assign ctrl_rdata = s_q.ctrl;
    assign stat_rdata = s_q.stat;
    assign accumulated_charge_count_rdata = s_q.accumulated_charge_count;

    property p_ctrl_rst;
        @(posedge clk) rst |=> ctrl_rdata == `GCAP_CTRL_RST && pin_oe_n;
    endproperty
    a_ctrl_rst: assert property (p_ctrl_rst) else $error("Wrong control reset."); // RULE_04

    property p_ctrl_wr;
        @(posedge clk) disable iff (rst)
        ctrl_wr |=> ctrl_rdata == $past(ctrl_wdata);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("Control write lost."); // RULE_01

    property p_single;
        @(posedge clk) disable iff (rst)
        (adc_mode == gcap_pkg::GCAP_MODE_SINGLE && seq_done && !ctrl_wr)
            |=> adc_mode == gcap_pkg::GCAP_MODE_SLEEP;
    endproperty
    a_single: assert property (p_single) else $error("Single mode did not return to sleep."); // RULE_13

    property p_alert_set;
        @(posedge clk) disable iff (rst)
        (pin_cfg == gcap_pkg::GCAP_PIN_ALERT && (meas_evt.volt || meas_evt.cur))
            |=> !pin_oe_n;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("Alert not driven."); // RULE_05

    property p_alert_hold;
        @(posedge clk) disable iff (rst)
        (!pin_oe_n && !ara_done) |=> !pin_oe_n;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("Alert released early."); // RULE_07

    property p_alert_off;
        @(posedge clk) disable iff (rst)
        (pin_cfg == gcap_pkg::GCAP_PIN_OFF && pin_oe_n) |=> pin_oe_n;
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("Disabled pin driven."); // RULE_09

    property p_chg_full;
        @(posedge clk) disable iff (rst)
        (pin_cfg == gcap_pkg::GCAP_PIN_CHG_FULL && !pin_i)
            |=> accumulated_charge_count_rdata == `GCAP_COUNT_FULL;
    endproperty
    a_chg_full: assert property (p_chg_full) else $error("Charge-full load missed."); // RULE_08

    property p_wrap;
        @(posedge clk) disable iff (rst)
        (cnt_inc && accumulated_charge_count_rdata == `GCAP_COUNT_FULL &&
            !accumulated_charge_count_wr && !chg_full)
            |=> accumulated_charge_count_rdata == `GCAP_COUNT_ZERO &&
            stat_rdata[`GCAP_STAT_OVF];
    endproperty
    a_wrap: assert property (p_wrap) else $error("Wrap not flagged."); // RULE_15

    property p_shdn_hold;
        @(posedge clk) disable iff (rst)
        (shdn && $past(shdn) && !accumulated_charge_count_wr && !chg_full)
            |=> $stable(accumulated_charge_count_rdata);
    endproperty
    a_shdn_hold: assert property (p_shdn_hold) else $error("Counting in shutdown."); // RULE_12

    property p_stat_clr;
        @(posedge clk) disable iff (rst)
        (stat_rd && stat_set == 8'h00) |=> stat_rdata == 8'h00;
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("Status not cleared by read."); // RULE_16

    c_alert_ara: cover property (@(posedge clk) disable iff (rst) !pin_oe_n ##[1:20] ara_done);
    c_wrap: cover property (@(posedge clk) disable iff (rst) wrap);
    c_chg_full: cover property (@(posedge clk) disable iff (rst) chg_full);
    c_single: cover property (@(posedge clk) disable iff (rst)
        adc_mode == gcap_pkg::GCAP_MODE_SINGLE && seq_done);

endmodule

// file: gcap_far_model.sv
// Far side of the alert pin: pull-up resistor, device drive and a charger.
// Assumes the bench drives charger_low from its clock edge.
`timescale 1ns/100ps
module gcap_far_model
(
    input wire logic pin_o, // Device drive level.
    input wire logic pin_oe_n, // Device drive enable, low while driving.
    input wire logic charger_low, // Charger reports full by pulling low.
    output logic pin_i // Resolved pin level.
);
    // Either party can only pull low, so the resistor gives a high otherwise.
    assign pin_i = ((!pin_oe_n && !pin_o) || charger_low) ? 1'b0 : 1'b1;
endmodule

// file: gcap_ctrl_tb_top.sv
// Self-checking bench for the gauge control block and its alert pin.
// Assumes the package, header and far-side model are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module gcap_ctrl_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ctrl_wr = 1'b0, stat_rd = 1'b0, count_wr = 1'b0, chg_low = 1'b0;
    logic step_up = 1'b0, step_dn = 1'b0, seq_done = 1'b0, ara_done = 1'b0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [15:0] count_wdata = 16'h0000;
    gcap_pkg::gcap_evt_t meas_evt = 6'h00;
    logic [7:0] ctrl_rdata, stat_rdata;
    logic [15:0] count_rdata, exp_count;
    logic pin_i, pin_o, pin_oe_n, analog_on;
    gcap_pkg::gcap_mode_t adc_mode;
    int err_count = 0, n_checks = 0, cyc = 0;

    // Free-running clock at 20 MHz.
    always #25 clk = ~clk;

    gcap_ctrl gcap_ctrl_inst (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .stat_rd(stat_rd),
        .stat_rdata(stat_rdata), .accumulated_charge_count_wr(count_wr),
        .accumulated_charge_count_wdata(count_wdata),
        .accumulated_charge_count_rdata(count_rdata),
        .step_up(step_up), .step_dn(step_dn),
        .meas_evt(meas_evt), .seq_done(seq_done), .ara_done(ara_done),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .analog_on(analog_on), .adc_mode(adc_mode));
    gcap_far_model gcap_far_model_inst (.pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .charger_low(chg_low), .pin_i(pin_i));

    // Verdict and end of run.
    task summarize;
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Control write; the host never places code 11 in the pin field.
    task wc(input logic [7:0] v);
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= v;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        @(negedge clk);
    endtask

    // Charge count write.
    task wa(input logic [15:0] v);
        @(posedge clk);
        count_wr <= 1'b1;
        count_wdata <= v;
        @(posedge clk);
        count_wr <= 1'b0;
        @(negedge clk);
    endtask

    // Holds a step line for n cycles, then waits out the two-cycle count latency.
    task stp(input int n, input logic up);
        @(posedge clk);
        step_up <= up;
        step_dn <= !up;
        repeat (n) @(posedge clk);
        step_up <= 1'b0;
        step_dn <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    // One-cycle event pulse from the measurement side.
    task evt(input logic [5:0] e);
        @(posedge clk);
        meas_evt <= e;
        @(posedge clk);
        meas_evt <= 6'h00;
        @(negedge clk);
    endtask

    // Host completes an alert response.
    task ara;
        @(posedge clk);
        ara_done <= 1'b1;
        @(posedge clk);
        ara_done <= 1'b0;
        @(negedge clk);
    endtask

    // Host reads the status register, which clears it.
    task srd;
        @(posedge clk);
        stat_rd <= 1'b1;
        @(posedge clk);
        stat_rd <= 1'b0;
        @(negedge clk);
    endtask

    // Charger holds the pin low for two cycles, then releases it.
    task chg;
        @(posedge clk);
        chg_low <= 1'b1;
        repeat (2) @(posedge clk);
        chg_low <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // Cuts a hang short; the tests need just under 10000 cycles.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK(ctrl_rdata, 8'h3c)
        `CHK(count_rdata, 16'h7fff)
        `CHK(pin_oe_n, 1'b1)
        `CHK(pin_o, 1'b0)
        `CHK(analog_on, 1'b1)
        `CHK(adc_mode, gcap_pkg::GCAP_MODE_SLEEP)
        // Both top codes need 4096 steps, not one fewer.
        stp(4095, 1'b1);
        `CHK(count_rdata, 16'h7fff)
        stp(1, 1'b1);
        `CHK(count_rdata, 16'h8000)
        wc(8'h34);
        stp(4095, 1'b1);
        `CHK(count_rdata, 16'h8000)
        stp(1, 1'b1);
        `CHK(count_rdata, 16'h8001)
        exp_count = 16'h8001;
        for (int c = 0; c < 6; c++)
        begin
            wc({2'h0, c[2:0], 3'h4});
            // A factor of one has no partial steps, so there is nothing to hold back.
            if (c > 0)
            begin
                stp((1 << (2 * c)) - 1, 1'b0);
            end
            `CHK(count_rdata, exp_count)
            stp(1, 1'b0);
            exp_count = exp_count - 16'h0001;
            `CHK(count_rdata, exp_count)
        end
        // Shutdown keeps registers, blocks steps and drops the residue.
        wc(8'h0c);
        stp(3, 1'b1);
        wc(8'h0d);
        `CHK(analog_on, 1'b0)
        `CHK(ctrl_rdata, 8'h0d)
        stp(2, 1'b1);
        `CHK(count_rdata, exp_count)
        wc(8'h0c);
        stp(3, 1'b1);
        `CHK(count_rdata, exp_count)
        stp(1, 1'b1);
        `CHK(count_rdata, exp_count + 16'h0001)
        // Wrap raises an alert that outlives a pin reconfiguration.
        wc(8'h04);
        wa(16'hffff);
        stp(1, 1'b1);
        `CHK(count_rdata, 16'h0000)
        `CHK(stat_rdata[5], 1'b1)
        `CHK(pin_i, 1'b0)
        wc(8'h00);
        `CHK(pin_oe_n, 1'b0)
        ara();
        `CHK(pin_oe_n, 1'b1)
        srd();
        `CHK(stat_rdata, 8'h00)
        stp(1, 1'b0);
        `CHK(count_rdata, 16'hffff)
        `CHK(stat_rdata[5], 1'b1)
        `CHK(pin_oe_n, 1'b1)
        evt(6'h20);
        `CHK(pin_oe_n, 1'b1)
        wa(16'h1234);
        chg();
        `CHK(count_rdata, 16'h1234)
        wc(8'h02);
        chg();
        `CHK(count_rdata, 16'hffff)
        // Each threshold event in alert mode; undervoltage alone does not alert.
        wc(8'h04);
        evt(6'h01);
        `CHK(pin_oe_n, 1'b1)
        for (int k = 1; k < 6; k++)
        begin
            srd();
            evt(6'h01 << k);
            `CHK(pin_oe_n, 1'b0)
            `CHK(stat_rdata, (k == 5) ? 8'h40 : (8'h01 << k))
            ara();
        end
        // A read or a response that meets a new event in one cycle loses to it.
        @(posedge clk);
        stat_rd <= 1'b1;
        ara_done <= 1'b1;
        meas_evt <= 6'h02;
        @(posedge clk);
        stat_rd <= 1'b0;
        ara_done <= 1'b0;
        meas_evt <= 6'h00;
        @(negedge clk);
        `CHK(stat_rdata, 8'h02)
        `CHK(pin_oe_n, 1'b0)
        ara();
        `CHK(pin_oe_n, 1'b1)
        // Converter modes; single returns to sleep when the sequence ends.
        wc(8'h84);
        `CHK(adc_mode, gcap_pkg::GCAP_MODE_SCAN)
        wc(8'hc4);
        `CHK(adc_mode, gcap_pkg::GCAP_MODE_AUTO)
        wc(8'h44);
        `CHK(adc_mode, gcap_pkg::GCAP_MODE_SINGLE)
        @(posedge clk);
        seq_done <= 1'b1;
        @(posedge clk);
        seq_done <= 1'b0;
        @(negedge clk);
        `CHK(ctrl_rdata, 8'h04)
        summarize();
    end
endmodule
